/* rtl/esd_defines.vh */
// register offsets, field positions, reset values and timing for the sequencer
`ifndef ESD_DEFINES_VH
`define ESD_DEFINES_VH
`define ESD_ADDR_REG1_DELAY   8'h0f
`define ESD_ADDR_OUT1_DELAY   8'h10
`define ESD_ADDR_OUT2_DELAY   8'h11
`define ESD_ADDR_OUT_CTRL     8'h12
`define ESD_ADDR_CONFIG       8'h13
`define ESD_OFF_HI            7
`define ESD_OFF_LO            4
`define ESD_ON_HI             3
`define ESD_ON_LO             0
`define ESD_CTL_OUT1_LEVEL    0
`define ESD_CTL_OUT1_GATING   1
`define ESD_CTL_OUT1_OD       2
`define ESD_CTL_OUT2_LEVEL    4
`define ESD_CTL_OUT2_GATING   5
`define ESD_CTL_OUT2_OD       6
`define ESD_CTL_WMASK         8'h77
`define ESD_CFG_ON_RANGE      6
`define ESD_CFG_OFF_RANGE     5
`define ESD_DELAY_RESET       8'h00
`define ESD_CTRL_RESET        8'h00
`define ESD_CFG_RESET         8'h00
`define ESD_CLK_MHZ           250
`define ESD_STEP_US           500
`define ESD_STEP_CYCLES       (`ESD_STEP_US * `ESD_CLK_MHZ)
`endif

/* rtl/esd_delay_chan.v */
// one delayed-edge channel: follows enable edges after a coded step delay
`timescale 1ns/1ps
`default_nettype none
module esd_delay_chan (
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    input  wire       en_i,
    input  wire       en_rise_i,
    input  wire       en_fall_i,
    input  wire       half_tick_i,
    input  wire       full_tick_i,
    input  wire [3:0] on_code_i,
    input  wire [3:0] off_code_i,
    input  wire       on_range_i,
    input  wire       off_range_i,
    output reg        state_o
);
    reg [3:0] cnt_reg;
    reg       pend_reg;
    wire      tick;

    // step tick chosen by the range of the pending direction
    assign tick = en_i ? (on_range_i ? full_tick_i : half_tick_i)
                       : (off_range_i ? full_tick_i : half_tick_i);

    // load on each edge; a reversed edge reloads and so cancels
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg  <= 4'h0;
            pend_reg <= 1'b0;
            state_o  <= 1'b0;
        end else if (en_rise_i) begin
            cnt_reg  <= on_code_i;
            pend_reg <= (on_code_i != 4'h0);
            if (on_code_i == 4'h0)
                state_o <= 1'b1;
        end else if (en_fall_i) begin
            cnt_reg  <= off_code_i;
            pend_reg <= (off_code_i != 4'h0);
            if (off_code_i == 4'h0)
                state_o <= 1'b0;
        end else if (pend_reg && tick) begin
            if (cnt_reg == 4'h1) begin
                pend_reg <= 1'b0;
                state_o  <= en_i;
            end
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule // esd_delay_chan
`default_nettype wire

/* rtl/esd_sequencer.v */
// enable-pin sequencing for regulator two and two general outputs
`timescale 1ns/1ps
`default_nettype none
`include "esd_defines.vh"
// Operation
// - regulator two turns off after coded delay from enable fall
// - shutdown range bit makes each shutdown step 1 ms
// - regulator two turns on after coded delay from enable rise
// - startup range bit makes each startup step 1 ms
// - first output goes low after its shutdown delay
// - first output goes high after its startup delay
// - second output goes low after its shutdown delay
// - second output goes high after its startup delay
// - control bit 6 selects open-drain for second output
// - control bit 1 gates first output with delayed enable
// - control bit 5 gates second output with delayed enable
// - control bit 0 is first output level
// - control bit 4 is second output level, when pin is output
// - configuration bit 6 is startup range select
// - configuration bit 5 is shutdown range select
module esd_sequencer #(
    parameter STEP_CYCLES = `ESD_STEP_CYCLES
) (
    input  wire       sys_clk_i,
    input  wire       rstn_i,
    input  wire       en_pin_i,
    input  wire       out2_pin_sel_i,
    input  wire       reg_wr_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    output reg        reg2_enable_o,
    output reg        out1_o,
    output reg        out1_oe_o,
    output reg        out2_o,
    output reg        out2_oe_o
);
    reg [7:0]  reg1_delay_reg;
    reg [7:0]  out1_delay_reg;
    reg [7:0]  out2_delay_reg;
    reg [7:0]  ctrl_reg;
    reg [7:0]  cfg_reg;
    reg [31:0] div_reg;
    reg        half_tick_reg;
    reg        odd_reg;
    reg        en_d_reg;
    reg [7:0]  rd_next;
    wire       en_rise;
    wire       en_fall;
    wire       full_tick;
    wire       reg2_on;
    wire       out1_on;
    wire       out2_on;
    wire       out1_lvl;
    wire       out2_lvl;

    // enable edge detection
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            en_d_reg <= 1'b0;
        else
            en_d_reg <= en_pin_i;
    end
    assign en_rise = en_pin_i & ~en_d_reg;
    assign en_fall = ~en_pin_i & en_d_reg;

    // shared tick divider, restarted at each enable edge
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg       <= 32'h0;
            half_tick_reg <= 1'b0;
            odd_reg       <= 1'b0;
        end else if (en_rise || en_fall) begin
            div_reg       <= 32'h0;
            half_tick_reg <= 1'b0;
            odd_reg       <= 1'b0;
        end else if (div_reg == STEP_CYCLES - 1) begin
            div_reg       <= 32'h0;
            half_tick_reg <= 1'b1;
            odd_reg       <= ~odd_reg;
        end else begin
            div_reg       <= div_reg + 32'h1;
            half_tick_reg <= 1'b0;
        end
    end
    // 1 ms tick every second half step
    assign full_tick = half_tick_reg & ~odd_reg;

    esd_delay_chan u_reg2 (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .en_i        (en_pin_i),
        .en_rise_i   (en_rise),
        .en_fall_i   (en_fall),
        .half_tick_i (half_tick_reg),
        .full_tick_i (full_tick),
        .on_code_i   (reg1_delay_reg[`ESD_ON_HI:`ESD_ON_LO]),
        .off_code_i  (reg1_delay_reg[`ESD_OFF_HI:`ESD_OFF_LO]),
        .on_range_i  (cfg_reg[`ESD_CFG_ON_RANGE]),
        .off_range_i (cfg_reg[`ESD_CFG_OFF_RANGE]),
        .state_o     (reg2_on)
    );

    esd_delay_chan u_out1 (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .en_i        (en_pin_i),
        .en_rise_i   (en_rise),
        .en_fall_i   (en_fall),
        .half_tick_i (half_tick_reg),
        .full_tick_i (full_tick),
        .on_code_i   (out1_delay_reg[`ESD_ON_HI:`ESD_ON_LO]),
        .off_code_i  (out1_delay_reg[`ESD_OFF_HI:`ESD_OFF_LO]),
        .on_range_i  (cfg_reg[`ESD_CFG_ON_RANGE]),
        .off_range_i (cfg_reg[`ESD_CFG_OFF_RANGE]),
        .state_o     (out1_on)
    );

    esd_delay_chan u_out2 (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .en_i        (en_pin_i),
        .en_rise_i   (en_rise),
        .en_fall_i   (en_fall),
        .half_tick_i (half_tick_reg),
        .full_tick_i (full_tick),
        .on_code_i   (out2_delay_reg[`ESD_ON_HI:`ESD_ON_LO]),
        .off_code_i  (out2_delay_reg[`ESD_OFF_HI:`ESD_OFF_LO]),
        .on_range_i  (cfg_reg[`ESD_CFG_ON_RANGE]),
        .off_range_i (cfg_reg[`ESD_CFG_OFF_RANGE]),
        .state_o     (out2_on)
    );

    // register writes
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg1_delay_reg <= `ESD_DELAY_RESET;
            out1_delay_reg <= `ESD_DELAY_RESET;
            out2_delay_reg <= `ESD_DELAY_RESET;
            ctrl_reg       <= `ESD_CTRL_RESET;
            cfg_reg        <= `ESD_CFG_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `ESD_ADDR_REG1_DELAY: reg1_delay_reg <= reg_wdata_i;
                `ESD_ADDR_OUT1_DELAY: out1_delay_reg <= reg_wdata_i;
                `ESD_ADDR_OUT2_DELAY: out2_delay_reg <= reg_wdata_i;
                `ESD_ADDR_OUT_CTRL:   ctrl_reg <= reg_wdata_i & `ESD_CTL_WMASK;
                `ESD_ADDR_CONFIG:     cfg_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // read data mux, unmapped reads zero
    always @* begin
        case (reg_addr_i)
            `ESD_ADDR_REG1_DELAY: rd_next = reg1_delay_reg;
            `ESD_ADDR_OUT1_DELAY: rd_next = out1_delay_reg;
            `ESD_ADDR_OUT2_DELAY: rd_next = out2_delay_reg;
            `ESD_ADDR_OUT_CTRL:   rd_next = ctrl_reg;
            `ESD_ADDR_CONFIG:     rd_next = cfg_reg;
            default:              rd_next = 8'h00;
        endcase
    end

    // first level, optionally gated by delayed enable
    assign out1_lvl = ctrl_reg[`ESD_CTL_OUT1_LEVEL] &
                      (~ctrl_reg[`ESD_CTL_OUT1_GATING] | out1_on);
    // second level, optionally gated by delayed enable
    assign out2_lvl = ctrl_reg[`ESD_CTL_OUT2_LEVEL] &
                      (~ctrl_reg[`ESD_CTL_OUT2_GATING] | out2_on);

    // registered outputs and pin drivers
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o   <= 8'h00;
            reg2_enable_o <= 1'b0;
            out1_o        <= 1'b0;
            out1_oe_o     <= 1'b0;
            out2_o        <= 1'b0;
            out2_oe_o     <= 1'b0;
        end else begin
            reg_rdata_o   <= rd_next;
            reg2_enable_o <= reg2_on;
            out1_o        <= out1_lvl;
            out1_oe_o     <= ~(ctrl_reg[`ESD_CTL_OUT1_OD] & out1_lvl);
            out2_o        <= out2_lvl;
            // pin released when used as clock input
            out2_oe_o     <= ~out2_pin_sel_i &
                             ~(ctrl_reg[`ESD_CTL_OUT2_OD] & out2_lvl);
        end
    end
endmodule // esd_sequencer
`default_nettype wire

/* testbench/esd_props.sv */
// port checks for the enable sequencer
`timescale 1ns/1ps
`default_nettype none
module esd_props (
    input wire logic       sys_clk_i,
    input wire logic       rstn_i,
    input wire logic       en_pin_i,
    input wire logic       out2_pin_sel_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg2_enable_o,
    input wire logic       out1_o,
    input wire logic       out1_oe_o,
    input wire logic       out2_o,
    input wire logic       out2_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // a write to the output control register
    wire ctl_wr = reg_wr_i && reg_addr_i == 8'h12;
    rsv_bits_zero_a: assert property (reg_addr_i == 8'h12 |=>
        !reg_rdata_o[7] && !reg_rdata_o[3]) else $error("reserved bit set");
    out1_high_a: assert property (ctl_wr && reg_wdata_i[1:0] == 2'b01
        |-> ##[1:2] out1_o) else $error("first output not high");
    out1_low_a: assert property (ctl_wr && !reg_wdata_i[0]
        |-> ##[1:2] !out1_o) else $error("first output not low");
    out2_high_a: assert property (ctl_wr && reg_wdata_i[5:4] == 2'b01
        && !out2_pin_sel_i |-> ##[1:2] out2_o) else $error("out2 not high");
    pin_release_a: assert property (out2_pin_sel_i
        |-> ##[1:2] !out2_oe_o) else $error("shared pin still driven");
    od_release_a: assert property ($past(rstn_i) && !out1_oe_o
        |-> out1_o) else $error("driver released while low");
    en_low_hold_a: assert property (!en_pin_i [*4] ##0 !reg2_enable_o
        |=> !reg2_enable_o) else $error("regulator on with enable low");
    en_high_hold_a: assert property (en_pin_i [*4] ##0 reg2_enable_o
        |=> reg2_enable_o) else $error("regulator off with enable high");
    cover property ($rose(reg2_enable_o));
    cover property ($fell(out1_o));
    cover property ($fell(out2_oe_o));
endmodule // esd_props
`default_nettype wire

/* testbench/esd_host.sv */
// host model: drives the enable pin and the register port
`timescale 1ns/1ps
`default_nettype none
module esd_host (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output var  logic       en_pin_o,
    output var  logic       pin_sel_o,
    output var  logic       wr_o,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o
);
    // idle port at time zero
    initial begin
        {en_pin_o, pin_sel_o, wr_o, addr_o, wdata_o} = '0;
    end
    // one write; data turned over once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // select a register, take its data a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        d = reg_rdata_i;
    endtask
    // set enable and shared pin select
    task automatic pins(input logic e, input logic s);
        @(posedge sys_clk_i);
        en_pin_o <= e;
        pin_sel_o <= s;
    endtask
endmodule // esd_host
`default_nettype wire

/* testbench/tb_esd_sequencer.sv */
// self-checking bench for the enable sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_esd_sequencer;
    localparam int STEP = 4;
    logic       clk, rstn, en, sel, wr, reg2, o1, oe1, o2, oe2;
    logic [7:0] addr, wdata, rdata, d, v;
    logic [23:0] c;
    logic [7:0] ctl[4] = '{8'h55, 8'h11, 8'h00, 8'h11};
    logic [7:0] ex[4]  = '{8'h0a, 8'h0f, 8'h05, 8'h0c};
    integer     seed, n_errors, checks_done, t[3];
    esd_host i_esd_host (.sys_clk_i(clk), .reg_rdata_i(rdata),
        .en_pin_o(en), .pin_sel_o(sel), .wr_o(wr), .addr_o(addr),
        .wdata_o(wdata));
    esd_sequencer #(.STEP_CYCLES(STEP)) i_esd_sequencer (.sys_clk_i(clk),
        .rstn_i(rstn), .en_pin_i(en), .out2_pin_sel_i(sel), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg2_enable_o(reg2), .out1_o(o1), .out1_oe_o(oe1), .out2_o(o2),
        .out2_oe_o(oe2));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // expected read data: unmapped reads zero
    function automatic logic [7:0] ev(input int a, input logic [7:0] x);
        if (a == 8'h12) return x & 8'h77;
        return (a < 8'h0f || a > 8'h13) ? 8'h00 : x;
    endfunction
    // expected delay in cycles for a code and range
    function automatic int ed(input logic [3:0] k, input logic rng);
        return k * STEP * (rng ? 2 : 1);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // measured cycles must land just after the coded delay
    task automatic chk_t(input int got, input int exp);
        checks_done++;
        if (got < exp + 1 || got > exp + 6) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // move enable, time regulator and both outputs
    task automatic measure(input logic e);
        t = '{-1, -1, -1};
        i_esd_host.pins(e, 1'b0);
        for (int k = 1; k < 200; k++) begin
            @(negedge clk);
            if (t[0] < 0 && reg2 === e) t[0] = k;
            if (t[1] < 0 && o1 === e) t[1] = k;
            if (t[2] < 0 && o2 === e) t[2] = k;
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #48000;
        n_errors++;
        report_and_stop;
    end
    // reset, registers, output control, delays, cancel
    initial begin
        seed = 32'h6162;
        n_errors = 0;
        checks_done = 0;
        rstn = 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 8'h0e; a <= 8'h14; a++) begin
            i_esd_host.rd(8'(a), d);
            chk(d, 8'h00);
            v = 8'($random(seed));
            i_esd_host.wr(8'(a), v);
            i_esd_host.rd(8'(a), d);
            chk(d, ev(a, v));
        end
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            i_esd_host.wr(8'h12, ctl[i]);
            i_esd_host.pins(1'b0, i == 3);
            repeat (3) @(negedge clk);
            chk({4'h0, o1, oe1, o2 & ~sel, oe2}, ex[i]);
        end
        $display("output control done");
        for (int r = 0; r < 4; r++) begin
            c = (r == 0) ? 24'h0 : (r == 3) ? 24'hffffff : 24'($random(seed));
            i_esd_host.wr(8'h13, {1'b0, r[1], r[0], 5'h0});
            i_esd_host.wr(8'h0f, c[7:0]);
            i_esd_host.wr(8'h10, c[15:8]);
            i_esd_host.wr(8'h11, c[23:16]);
            i_esd_host.wr(8'h12, 8'h33);
            measure(1'b1);
            for (int i = 0; i < 3; i++) begin
                chk_t(t[i], ed(c[8*i +: 4], r[1]));
            end
            measure(1'b0);
            for (int i = 0; i < 3; i++) begin
                chk_t(t[i], ed(c[8*i+4 +: 4], r[0]));
            end
        end
        $display("delays done");
        i_esd_host.wr(8'h13, 8'h60);
        i_esd_host.wr(8'h0f, 8'h0f);
        i_esd_host.pins(1'b1, 1'b0);
        repeat (10) @(posedge clk);
        i_esd_host.pins(1'b0, 1'b0);
        // nothing may rise once the pending startups are cancelled
        v = 8'h00;
        repeat (200) begin
            @(negedge clk);
            v = v | {5'h0, reg2, o1, o2};
        end
        chk(v, 8'h00);
        $display("cancel done");
        // reset in mid-run clears outputs and registers
        i_esd_host.wr(8'h12, 8'h11);
        i_esd_host.pins(1'b1, 1'b0);
        repeat (4) @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(negedge clk);
        chk({3'h0, reg2, o1, oe1, o2, oe2}, 8'h00);
        @(posedge clk);
        rstn <= 1'b1;
        i_esd_host.rd(8'h12, d);
        chk(d, 8'h00);
        $display("reset done");
        report_and_stop;
    end
endmodule // tb_esd_sequencer
bind esd_sequencer esd_props i_esd_props (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .en_pin_i(en_pin_i), .out2_pin_sel_i(out2_pin_sel_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg2_enable_o(reg2_enable_o),
    .out1_o(out1_o), .out1_oe_o(out1_oe_o), .out2_o(out2_o),
    .out2_oe_o(out2_oe_o));
`default_nettype wire
